// file: src/swpmc_pkg.sv
// swpmc_pkg: constants and state encoding of the sleep/wake power mode controller.
// assumes a single 100 MHz reference clock and a synchronous active-low reset.
package swpmc_pkg;
  // clock and step timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_NS = 1000;  // least settle time of one sequencing step
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 16;
  // counter and memory geometry
  localparam int RTC_W = 64;
  localparam logic [63:0] RTC_RESET = 64'h0;
  localparam int DSM_BYTES = 128;
  localparam int DSM_AW = 7;
  localparam logic [7:0] DSM_RESET = 8'h00;
  // power states, awake and asleep plus the steps between
  typedef enum logic [2:0] {
    ST_AWAKE = 3'b000,
    ST_GO_RST = 3'b001,
    ST_GO_CLK = 3'b010,
    ST_GO_PWR = 3'b011,
    ST_ASLEEP = 3'b100,
    ST_UP_PWR = 3'b101,
    ST_UP_CLK = 3'b110,
    ST_UP_RST = 3'b111
  } swpmc_state_t;
endpackage : swpmc_pkg

// file: src/swpmc_dsm.sv
// swpmc_dsm: deep sleep memory, byte wide, flip-flop storage.
// assumes it sits on the always-on supply so contents survive sleep.
`timescale 1ns/100ps
`default_nettype none
module swpmc_dsm #(
  parameter int BYTES = swpmc_pkg::DSM_BYTES,
  parameter int AW = swpmc_pkg::DSM_AW
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  import swpmc_pkg::*;

  // refuse a depth that the address cannot reach
  if (BYTES > (1 << AW)) begin : g_bad_depth
    $error("swpmc_dsm: BYTES does not fit AW");
  end

  typedef struct packed {
    logic [BYTES-1:0][7:0] mem;
    logic [7:0] rd;
  } swpmc_dsm_st_t;

  swpmc_dsm_st_t s;
  swpmc_dsm_st_t next_s;

  // registered read then write; read returns the old byte on a same-address write
  always_comb begin
    next_s = s;
    next_s.rd = s.mem[addr];
    if (wr) begin
      next_s.mem[addr] = wdata;
    end
  end

  // contents cleared only by reset, never by the sleep sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '{mem: {BYTES{DSM_RESET}}, rd: DSM_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rd;
endmodule : swpmc_dsm
`default_nettype wire

// file: src/swpmc_top.sv
// swpmc_top: moves the device between awake and asleep, keeps the real-time counter.
// assumes ref_clk is the main oscillator; pins and the slow tick arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module swpmc_top #(
  parameter int STEPS = swpmc_pkg::STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sleep_req,
  input wire logic usb_standby_req,
  input wire logic usb_enable,
  input wire logic usb_host_wake,
  input wire logic wake_pin,
  input wire logic wake_pin_en,
  input wire logic wake_pin_level,
  input wire logic rtc_wake_en,
  input wire logic [swpmc_pkg::RTC_W-1:0] rtc_compare,
  input wire logic slow_osc_sel,
  input wire logic slow_tick,
  input wire logic [swpmc_pkg::RTC_W-1:0] slow_increment,
  input wire logic power_good,
  input wire logic dsm_wr,
  input wire logic [swpmc_pkg::DSM_AW-1:0] dsm_addr,
  input wire logic [7:0] dsm_wdata,
  output logic [7:0] dsm_rdata,
  output logic awake,
  output logic asleep,
  output logic node_power_on,
  output logic node_clock_mask,
  output logic node_reset,
  output logic watchdog_enable,
  output logic io_supply_out_on,
  output logic system_reset,
  output logic rtc_on_slow,
  output logic [swpmc_pkg::RTC_W-1:0] rtc_count
);
  import swpmc_pkg::*;

  // refuse a step count that the down-counter cannot hold
  if (STEPS < 1 || STEPS >= (1 << STEP_CNT_W)) begin : g_bad_steps
    $error("swpmc_top: STEPS out of range");
  end

  typedef struct packed {
    swpmc_state_t st;
    logic [STEP_CNT_W-1:0] cnt;
    logic pend;
    logic [RTC_W-1:0] rtc;
    logic pin_s1, pin_s2, pin_prev;
    logic tick_s1, tick_s2, tick_prev;
    logic pg_s1, pg_s2;
    logic sysrst;
    logic [5:0] outs;
  } swpmc_st_t;

  swpmc_st_t s;
  swpmc_st_t next_s;
  logic wake_now;
  logic tick_edge;
  logic in_trans;

  // output pattern per state: power, mask, reset, watchdog, io supply, slow clock
  function automatic logic [5:0] state_outs(input swpmc_state_t st, input logic slow);
    logic pwr;
    logic msk;
    logic rst;
    logic run;
    pwr = !(st == ST_GO_PWR || st == ST_ASLEEP);
    msk = st inside {ST_GO_CLK, ST_GO_PWR, ST_ASLEEP, ST_UP_PWR};
    rst = !(st == ST_AWAKE || st == ST_UP_RST);
    run = (st == ST_AWAKE);
    state_outs = {pwr, msk, rst, run, run, slow && st == ST_ASLEEP};
  endfunction : state_outs

  // wake sources, each already qualified by its enable
  assign tick_edge = s.tick_s2 && !s.tick_prev;
  assign wake_now = (wake_pin_en && s.pin_s2 == wake_pin_level
                     && s.pin_prev != wake_pin_level)
                  || (rtc_wake_en && s.rtc >= rtc_compare)
                  || (usb_enable && usb_host_wake);
  assign in_trans = !(s.st == ST_AWAKE || s.st == ST_ASLEEP);

  always_comb begin
    next_s = s;
    next_s.sysrst = 1'b0;
    // synchronisers: first stage feeds only the second
    next_s.pin_s1 = wake_pin;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.tick_s1 = slow_tick;
    next_s.tick_s2 = s.tick_s1;
    next_s.tick_prev = s.tick_s2;
    next_s.pg_s1 = power_good;
    next_s.pg_s2 = s.pg_s1;
    // real-time counter; slow mode only while fully asleep
    if (s.st == ST_ASLEEP && slow_osc_sel) begin
      if (tick_edge) begin
        next_s.rtc = s.rtc + slow_increment;
      end
    end else begin
      next_s.rtc = s.rtc + 64'h1;
    end
    // wake stimuli are held from the first step down, dropped while awake
    if (s.st == ST_AWAKE) begin
      next_s.pend = 1'b0;
    end else if (wake_now) begin
      next_s.pend = 1'b1;
    end
    // each transition step waits its settle time before the next
    next_s.cnt = (s.cnt == '0) ? '0 : s.cnt - 1'b1;
    case (s.st)
      ST_AWAKE: begin
        if (sleep_req || usb_standby_req) begin
          next_s.st = ST_GO_RST;
          next_s.cnt = STEP_CNT_W'(STEPS - 1);
        end
      end
      ST_ASLEEP: begin
        if (s.pend || wake_now) begin
          next_s.st = ST_UP_PWR;
          next_s.cnt = STEP_CNT_W'(STEPS - 1);
          next_s.pend = 1'b0;
        end
      end
      default: begin
        if (s.cnt == '0) begin
          next_s.cnt = STEP_CNT_W'(STEPS - 1);
          case (s.st)
            ST_GO_RST: next_s.st = ST_GO_CLK;
            ST_GO_CLK: next_s.st = ST_GO_PWR;
            ST_GO_PWR: next_s.st = ST_ASLEEP;
            ST_UP_PWR: next_s.st = ST_UP_CLK;
            ST_UP_CLK: next_s.st = ST_UP_RST;
            default: next_s.st = ST_AWAKE;
          endcase
        end
      end
    endcase
    // losing power-good mid-sequence reboots as from cold; sleep requests are
    // simply not looked at outside awake
    if (in_trans && !s.pg_s2) begin
      next_s.st = ST_AWAKE;
      next_s.sysrst = 1'b1;
      next_s.rtc = RTC_RESET;
      next_s.pend = 1'b0;
    end
    next_s.outs = state_outs(next_s.st, slow_osc_sel);
  end

  // one register for the whole state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '{st: ST_AWAKE, cnt: '0, pend: 1'b0, rtc: RTC_RESET,
             pin_s1: 1'b0, pin_s2: 1'b0, pin_prev: 1'b0,
             tick_s1: 1'b0, tick_s2: 1'b0, tick_prev: 1'b0,
             pg_s1: 1'b1, pg_s2: 1'b1, sysrst: 1'b0, outs: 6'b100110};
    end else begin
      s <= next_s;
    end
  end

  swpmc_dsm i_swpmc_dsm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr(dsm_wr),
    .addr(dsm_addr),
    .wdata(dsm_wdata),
    .rdata(dsm_rdata)
  );

  assign awake = (s.st == ST_AWAKE);
  assign asleep = (s.st == ST_ASLEEP);
  assign {node_power_on, node_clock_mask, node_reset} = s.outs[5:3];
  assign {watchdog_enable, io_supply_out_on, rtc_on_slow} = s.outs[2:0];
  assign system_reset = s.sysrst;
  assign rtc_count = s.rtc;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_sleep_start;
    awake && (sleep_req || usb_standby_req) |=> s.st == ST_GO_RST;
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("sleep request not taken");
  property p_no_wake_awake;
    awake ##1 !system_reset |-> s.st inside {ST_AWAKE, ST_GO_RST};
  endproperty
  a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake acted while awake");
  property p_pend_wake;
    s.st == ST_GO_PWR && s.pend && s.cnt == '0 && s.pg_s2 |=> asleep ##1 s.st == ST_UP_PWR;
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("pending wake lost");
  property p_sleep_power;
    asleep |-> !node_power_on && node_clock_mask && node_reset;
  endproperty
  a_sleep_power: assert property (p_sleep_power) else $error("node powered while asleep");
  property p_wake;
    asleep && wake_now && s.pg_s2 |=> s.st == ST_UP_PWR;
  endproperty
  a_wake: assert property (p_wake) else $error("wake stimulus ignored asleep");
  property p_rtc_run;
    awake && !next_s.sysrst |=> rtc_count == $past(rtc_count) + 64'h1;
  endproperty
  a_rtc_run: assert property (p_rtc_run) else $error("counter not counting awake");
  property p_rtc_slow;
    asleep && slow_osc_sel ##0 (tick_edge || $stable(s.tick_s2))
      |=> rtc_count == $past(rtc_count) + ($past(tick_edge) ? $past(slow_increment) : 64'h0);
  endproperty
  a_rtc_slow: assert property (p_rtc_slow) else $error("slow counter step wrong");
  property p_pg_reset;
    in_trans && !s.pg_s2 |=> system_reset && awake ##1 !system_reset;
  endproperty
  a_pg_reset: assert property (p_pg_reset) else $error("power-good loss not reset");
  property p_run_only;
    watchdog_enable == awake && io_supply_out_on == awake;
  endproperty
  a_run_only: assert property (p_run_only) else $error("watchdog or io supply outside awake");
  property p_order;
    s.st == ST_GO_RST && s.pg_s2 |=> s.st inside {ST_GO_RST, ST_GO_CLK};
  endproperty
  a_order: assert property (p_order) else $error("sleep steps out of order");

  c_sleep: cover property (s.st == ST_GO_PWR ##1 asleep);
  c_wake_up: cover property (s.st == ST_UP_RST ##1 awake);
  c_pend: cover property (s.st == ST_GO_CLK && wake_now);
  c_pg_loss: cover property (system_reset);
endmodule : swpmc_top
`default_nettype wire

// file: sim/swpmc_far_side.sv
// swpmc_far_side: board side of the controller, wake pin and free slow oscillator.
// assumes the bench sets the pin level; the silicon oscillator runs free.
`timescale 1ns/100ps
`default_nettype none
module swpmc_far_side #(
  parameter int HALF_NS = 16000
) (
  input wire logic pin_drive,
  output var logic wake_pin,
  output var logic slow_tick
);
  // pin follows the board level, asserted or deasserted
  always_comb wake_pin = pin_drive;
  // 31,250 Hz tick, unrelated in phase to ref_clk
  initial begin
    slow_tick = 1'b0;
    forever #(HALF_NS) slow_tick = ~slow_tick;
  end
endmodule : swpmc_far_side
`default_nettype wire

// file: sim/sleep_wake_power_mode_controller_bench.sv
// bench for swpmc_top: walks sleep and wake sequences, counter and memory.
// assumes swpmc_pkg and swpmc_far_side are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_power_mode_controller_bench;
  import swpmc_pkg::*;
  localparam int STEPS = 2; // short settle so walks stay brief
  logic ref_clk = 0, rst_n = 0, sleep_req = 0, usb_standby_req = 0, usb_enable = 0;
  logic usb_host_wake = 0, wake_pin_en = 0, wake_pin_level = 1, rtc_wake_en = 0;
  logic slow_osc_sel = 0, power_good = 1, dsm_wr = 0, pin_drive = 1;
  logic [RTC_W-1:0] rtc_compare = 64'hffff_ffff_ffff_ffff, slow_increment = 64'h0, t0;
  logic [DSM_AW-1:0] dsm_addr = 7'h00;
  logic [7:0] dsm_wdata = 8'h00, dsm_rdata;
  logic wake_pin, slow_tick, awake, asleep, node_power_on, node_clock_mask, node_reset;
  logic watchdog_enable, io_supply_out_on, system_reset, rtc_on_slow;
  logic [RTC_W-1:0] rtc_count;
  int errors = 0, compares = 0, cycles = 0;
  swpmc_top #(.STEPS(STEPS)) i_swpmc_top (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sleep_req(sleep_req),
    .usb_standby_req(usb_standby_req),
    .usb_enable(usb_enable),
    .usb_host_wake(usb_host_wake),
    .wake_pin(wake_pin),
    .wake_pin_en(wake_pin_en),
    .wake_pin_level(wake_pin_level),
    .rtc_wake_en(rtc_wake_en),
    .rtc_compare(rtc_compare),
    .slow_osc_sel(slow_osc_sel),
    .slow_tick(slow_tick),
    .slow_increment(slow_increment),
    .power_good(power_good),
    .dsm_wr(dsm_wr),
    .dsm_addr(dsm_addr),
    .dsm_wdata(dsm_wdata),
    .dsm_rdata(dsm_rdata),
    .awake(awake),
    .asleep(asleep),
    .node_power_on(node_power_on),
    .node_clock_mask(node_clock_mask),
    .node_reset(node_reset),
    .watchdog_enable(watchdog_enable),
    .io_supply_out_on(io_supply_out_on),
    .system_reset(system_reset),
    .rtc_on_slow(rtc_on_slow),
    .rtc_count(rtc_count)
  );
  swpmc_far_side i_swpmc_far_side (.pin_drive(pin_drive), .wake_pin(wake_pin),
    .slow_tick(slow_tick));
  always #5 ref_clk = ~ref_clk;
  // ceiling well above the slow-tick waits of the rtc test
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // request while awake and again mid-descent, then check every step on the way down
  task automatic go_sleep(input logic via_usb, input logic wake_mid);
    if (via_usb) usb_standby_req = 1;
    else sleep_req = 1;
    tick(1);
    {sleep_req, usb_standby_req, usb_host_wake} = {2'b00, wake_mid};
    chk({awake, node_reset, watchdog_enable, io_supply_out_on}, 4'h4);
    tick(1);
    usb_host_wake = 0;
    sleep_req = 1; // late request must leave no trace
    tick(STEPS - 1);
    sleep_req = 0;
    chk({node_clock_mask, node_power_on}, 2'h3);
    tick(STEPS);
    chk({node_power_on, asleep}, 2'h0);
    tick(STEPS);
    chk({asleep, node_power_on, node_clock_mask, node_reset}, 4'hb);
  endtask : go_sleep
  // wait for the exit from asleep, then check the way up
  task automatic wake_walk();
    for (int i = 0; i < 8 && asleep === 1'b1; i++) tick(1);
    chk({asleep, node_power_on, node_clock_mask, node_reset}, 4'h7);
    tick(STEPS);
    chk({node_clock_mask, node_reset}, 2'h1);
    tick(STEPS);
    chk({node_reset, awake}, 2'h0);
    tick(STEPS);
    chk({awake, watchdog_enable, io_supply_out_on, node_reset}, 4'he);
  endtask : wake_walk
  task automatic test_usb_wake();
    go_sleep(0, 0);
    usb_host_wake = 1;
    tick(6);
    chk(asleep, 1);
    usb_enable = 1;
    tick(1);
    usb_host_wake = 0;
    wake_walk();
    go_sleep(1, 1);
    wake_walk();
    usb_enable = 0;
    $display("usb wake test done at %0t", $time);
  endtask : test_usb_wake
  // pin toggled while awake is not remembered
  task automatic test_pin_wake();
    {wake_pin_en, wake_pin_level, pin_drive} = 3'b100;
    tick(6);
    pin_drive = 1;
    tick(6);
    go_sleep(0, 0);
    tick(10);
    chk(asleep, 1);
    pin_drive = 0;
    wake_walk();
    // second pass wakes on the pin being asserted instead
    wake_pin_level = 1;
    go_sleep(0, 0);
    pin_drive = 1;
    wake_walk();
    wake_pin_en = 0;
    $display("pin wake test done at %0t", $time);
  endtask : test_pin_wake
  task automatic test_rtc();
    {rtc_wake_en, slow_osc_sel, slow_increment} = {2'b11, 64'h100};
    rtc_compare = rtc_count + 64'h300;
    go_sleep(0, 0);
    chk(rtc_on_slow, 1);
    t0 = rtc_count;
    for (int i = 0; i < 3300 && rtc_count === t0; i++) tick(1);
    chk(rtc_count - t0, 64'h100);
    for (int i = 0; i < 10000 && asleep === 1'b1; i++) tick(1);
    wake_walk();
    chk(rtc_on_slow, 0);
    t0 = rtc_count;
    tick(5);
    chk(rtc_count, t0 + 64'h5);
    {rtc_wake_en, slow_osc_sel} = 2'b00;
    $display("counter test done at %0t", $time);
  endtask : test_rtc
  task automatic test_power_fail();
    sleep_req = 1;
    tick(1);
    {sleep_req, power_good} = 2'b00;
    for (int i = 0; i < 8 && system_reset !== 1'b1; i++) tick(1);
    chk(system_reset, 1);
    tick(1);
    chk({system_reset, awake}, 2'h1);
    power_good = 1;
    tick(4);
    $display("test done at %0t", $time);
  endtask : test_power_fail
  task automatic test_dsm();
    {dsm_wr, dsm_addr, dsm_wdata} = {1'b1, 7'h7f, 8'ha5};
    tick(1);
    {dsm_addr, dsm_wdata} = {7'h00, 8'h3c};
    tick(1);
    dsm_wr = 0;
    go_sleep(0, 1);
    wake_walk();
    dsm_addr = 7'h7f;
    tick(1);
    chk(dsm_rdata, 8'ha5);
    dsm_addr = 7'h00;
    tick(1);
    chk(dsm_rdata, 8'h3c);
    $display("memory test done at %0t", $time);
  endtask : test_dsm
  // reset held 16 cycles, then the awake pattern must stand
  task automatic test_reset();
    tick(16);
    rst_n = 1;
    chk({awake, watchdog_enable, io_supply_out_on, node_power_on}, 4'hf);
    chk({node_reset, system_reset, asleep}, 3'h0);
    $display("reset test done at %0t", $time);
  endtask : test_reset
  initial begin
    usb_enable = 1;
    test_reset();
    usb_enable = 0;
    test_usb_wake();
    test_pin_wake();
    test_rtc();
    test_power_fail();
    usb_enable = 1;
    test_dsm();
    end_sim();
  end
endmodule : sleep_wake_power_mode_controller_bench
`default_nettype wire
